// ---- gpx_pkg.sv ----
// Package: register map, reset values and enums for the general-purpose port
package gpx_pkg;
   localparam int NPIN = 6;
   localparam int RST_PIN = 3;
   // Register byte offsets
   localparam logic [7:0] OFF_VALUE  = 8'h00;
   localparam logic [7:0] OFF_DIR    = 8'h04;
   localparam logic [7:0] OFF_CFG    = 8'h08;
   localparam logic [7:0] OFF_SENSE  = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   // Reset values
   localparam logic [7:0] RST_VALUE = 8'h00;
   localparam logic [7:0] RST_DIR   = 8'h08;
   localparam logic [7:0] RST_CFG   = 8'h02;
   localparam logic [1:0] RST_SENSE = 2'h0;
   // Sense field position within the sense register
   localparam int SENSE_LSB = 0;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      GPX_FALL_LOW = 2'h0,
      GPX_RISE     = 2'h1,
      GPX_FALL     = 2'h2,
      GPX_BOTH     = 2'h3
   } gpx_sense_e;
endpackage

// ---- gpx_port.sv ----
// General-purpose six-pin port with external interrupt request and AXI4-Lite registers
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module gpx_port #(
   parameter int NPIN = gpx_pkg::NPIN
) (
   // Clock and reset
   input  wire logic            clk_sys,
   input  wire logic            rst_n,
   // AXI4-Lite write address and data
   input  wire logic [7:0]      s_axi_awaddr,
   input  wire logic            s_axi_awvalid,
   output logic                 s_axi_awready,
   input  wire logic [31:0]     s_axi_wdata,
   input  wire logic [3:0]      s_axi_wstrb,
   input  wire logic            s_axi_wvalid,
   output logic                 s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]           s_axi_bresp,
   output logic                 s_axi_bvalid,
   input  wire logic            s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]      s_axi_araddr,
   input  wire logic            s_axi_arvalid,
   output logic                 s_axi_arready,
   output logic [31:0]          s_axi_rdata,
   output logic [1:0]           s_axi_rresp,
   output logic                 s_axi_rvalid,
   input  wire logic            s_axi_rready,
   // Pins, output enable low while driving
   input  wire logic [NPIN-1:0] pin_in,
   output logic [NPIN-1:0]      pin_out,
   output logic [NPIN-1:0]      pin_oe_n,
   output logic [NPIN-1:0]      pin_pullup,
   // Alternate function
   input  wire logic [NPIN-1:0] alt_out_en,
   input  wire logic [NPIN-1:0] alt_out_val,
   input  wire logic [NPIN-1:0] alt_out_pp,
   output logic [NPIN-1:0]      alt_in_val,
   // CPU side
   input  wire logic            cpu_vec_fetch,
   output logic                 ext_irq_req,
   output logic                 wake_req
);

   // ==========================================================
   // Registers
   logic [NPIN-1:0] pin_value_latch_r;
   logic [NPIN-1:0] pin_direction_r;
   logic [NPIN-1:0] pin_config_select_r;
   logic [1:0]      edge_sense_setting_r;
   logic [NPIN-1:0] sync1_r, sync2_r, sync3_r, pin_lvl_r;
   logic            det_prev_r;
   logic            pend_r;

   // ==========================================================
   // AXI4-Lite write channel
   logic            aw_hold_r, w_hold_r;
   logic [7:0]      aw_addr_r;
   logic [31:0]     w_data_r;
   logic [3:0]      w_strb_r;
   logic            wr_go;
   logic            wr_hit;

   // Commit once both halves are held and the last response has gone
   assign wr_go  = aw_hold_r && w_hold_r && !s_axi_bvalid;
   assign wr_hit = (aw_addr_r == gpx_pkg::OFF_VALUE) || (aw_addr_r == gpx_pkg::OFF_DIR)
                || (aw_addr_r == gpx_pkg::OFF_CFG) || (aw_addr_r == gpx_pkg::OFF_SENSE)
                || (aw_addr_r == gpx_pkg::OFF_STATUS);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_r     <= 1'b0;
         s_axi_awready <= 1'b0;
         aw_addr_r     <= 8'h00;
      end else begin
         s_axi_awready <= 1'b0;
         // One-cycle ready pulse; the held flag refuses a second address
         if (s_axi_awvalid && !aw_hold_r && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
            aw_hold_r     <= 1'b1;
            aw_addr_r     <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_hold_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         w_hold_r     <= 1'b0;
         s_axi_wready <= 1'b0;
         w_data_r     <= 32'h0000_0000;
         w_strb_r     <= 4'h0;
      end else begin
         s_axi_wready <= 1'b0;
         if (s_axi_wvalid && !w_hold_r && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
            w_hold_r     <= 1'b1;
            w_data_r     <= s_axi_wdata;
            w_strb_r     <= s_axi_wstrb;
         end else if (wr_go) begin
            w_hold_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= gpx_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? gpx_pkg::RESP_OKAY : gpx_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Port registers
   logic wr_b0;
   logic sense_wr;
   assign wr_b0    = wr_go && w_strb_r[0];
   assign sense_wr = wr_b0 && (aw_addr_r == gpx_pkg::OFF_SENSE);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_value_latch_r <= gpx_pkg::RST_VALUE[NPIN-1:0];
      end else if (wr_b0 && aw_addr_r == gpx_pkg::OFF_VALUE) begin
         pin_value_latch_r <= w_data_r[NPIN-1:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_direction_r <= gpx_pkg::RST_DIR[NPIN-1:0];
      end else if (wr_b0 && aw_addr_r == gpx_pkg::OFF_DIR) begin
         pin_direction_r <= w_data_r[NPIN-1:0];
         pin_direction_r[gpx_pkg::RST_PIN] <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_config_select_r <= gpx_pkg::RST_CFG[NPIN-1:0];
      end else if (wr_b0 && aw_addr_r == gpx_pkg::OFF_CFG) begin
         pin_config_select_r <= w_data_r[NPIN-1:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         edge_sense_setting_r <= gpx_pkg::RST_SENSE;
      end else if (sense_wr) begin
         edge_sense_setting_r <= w_data_r[gpx_pkg::SENSE_LSB +: 2];
      end
   end

   // ==========================================================
   // Input synchroniser, level accepted when stages two and three agree
   // Stages reset high so an idle pin shows no false edge
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r   <= '1;
         sync2_r   <= '1;
         sync3_r   <= '1;
         pin_lvl_r <= '1;
      end else begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         for (int i = 0; i < NPIN; i++) begin
            if (sync2_r[i] == sync3_r[i]) begin
               pin_lvl_r[i] <= sync3_r[i];
            end
         end
      end
   end

   // ==========================================================
   // Pin drivers and alternate function, one slice per pin
   logic [NPIN-1:0] irq_en;
   logic [NPIN-1:0] det_in;
   logic [NPIN-1:0] rd_value;

   // Peripheral drive wins over the port latch
   for (genvar g = 0; g < NPIN; g++) begin : g_pin
      logic drive_lo, drive_hi;
      assign irq_en[g] = !pin_direction_r[g] && pin_config_select_r[g];
      // Disabled interrupt pins count as high in the combine
      assign det_in[g] = irq_en[g] ? pin_lvl_r[g] : 1'b1;
      always_comb begin
         if (alt_out_en[g]) begin
            drive_lo = !alt_out_val[g];
            drive_hi = alt_out_val[g] && alt_out_pp[g];
         end else if (pin_direction_r[g]) begin
            drive_lo = !pin_value_latch_r[g];
            drive_hi = pin_value_latch_r[g] && pin_config_select_r[g];
         end else begin
            drive_lo = 1'b0;
            drive_hi = 1'b0;
         end
      end
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            pin_out[g]    <= 1'b0;
            pin_oe_n[g]   <= 1'b1;
            pin_pullup[g] <= 1'b0;
            alt_in_val[g] <= 1'b1;
         end else begin
            pin_out[g]    <= drive_hi;
            pin_oe_n[g]   <= !(drive_lo || drive_hi);
            pin_pullup[g] <= irq_en[g] && !alt_out_en[g];
            alt_in_val[g] <= pin_direction_r[g] ? pin_value_latch_r[g] : pin_lvl_r[g];
         end
      end
      always_comb begin
         if (pin_direction_r[g]) begin
            rd_value[g] = pin_value_latch_r[g];
         end else if (alt_out_en[g]) begin
            rd_value[g] = alt_out_val[g];
         end else begin
            rd_value[g] = pin_lvl_r[g];
         end
      end
   end

   // ==========================================================
   // Combined edge detector and pending latch
   logic det_now;
   logic hit;
   assign det_now = &det_in;
   always_comb begin
      unique case (gpx_sense_cast(edge_sense_setting_r))
         gpx_pkg::GPX_FALL_LOW: hit = !det_now;
         gpx_pkg::GPX_RISE:     hit = det_now && !det_prev_r;
         gpx_pkg::GPX_FALL:     hit = !det_now && det_prev_r;
         gpx_pkg::GPX_BOTH:     hit = det_now != det_prev_r;
      endcase
   end

   function automatic gpx_pkg::gpx_sense_e gpx_sense_cast(input logic [1:0] v);
      return gpx_pkg::gpx_sense_e'(v);
   endfunction

   // Prior level resets high to match the forced-high idle input
   // Sense write beats a new event, which beats a vector fetch
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         det_prev_r <= 1'b1;
         pend_r     <= 1'b0;
      end else begin
         det_prev_r <= det_now;
         if (sense_wr) begin
            pend_r <= 1'b0;
         end else if (hit) begin
            pend_r <= 1'b1;
         end else if (cpu_vec_fetch) begin
            pend_r <= 1'b0;
         end
      end
   end

   // Request and wake are flops mirroring the latch; the CPU mask lives in the core
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ext_irq_req <= 1'b0;
         wake_req    <= 1'b0;
      end else begin
         ext_irq_req <= (pend_r || hit) && !sense_wr && !(cpu_vec_fetch && !hit);
         wake_req    <= (pend_r || hit) && !sense_wr && !(cpu_vec_fetch && !hit);
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   // Unmapped offsets answer with a slave error and zero data
   logic [31:0] rd_mux;
   logic        rd_ok;
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_ok  = 1'b1;
      unique case (s_axi_araddr)
         gpx_pkg::OFF_VALUE:  rd_mux[NPIN-1:0] = rd_value;
         gpx_pkg::OFF_DIR:    rd_mux[NPIN-1:0] = pin_direction_r;
         gpx_pkg::OFF_CFG:    rd_mux[NPIN-1:0] = pin_config_select_r;
         gpx_pkg::OFF_SENSE:  rd_mux[1:0] = edge_sense_setting_r;
         gpx_pkg::OFF_STATUS: rd_mux[0] = pend_r;
         default:             rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= gpx_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_rvalid) begin
            if (s_axi_rready) begin
               s_axi_rvalid <= 1'b0;
            end
         end else if (s_axi_arready) begin
            // Data answers only after the address handshake at this edge
            s_axi_rvalid <= 1'b1;
         end else if (s_axi_arvalid) begin
            // Address stands until ready is seen, so it is safe to decode now
            s_axi_arready <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_ok ? gpx_pkg::RESP_OKAY : gpx_pkg::RESP_SLVERR;
         end
      end
   end

   // ==========================================================
   // Checks
   // Guards on the request latch and the pin drive
   sequence s_sense_write;
      sense_wr;
   endsequence

   a_sense_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_sense_write |=> !pend_r)
      else $error("pending survived sense change");
   a_fetch_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (cpu_vec_fetch && !hit && !sense_wr) |=> !pend_r)
      else $error("pending survived vector fetch");
   a_hit_sets: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (hit && !sense_wr) |=> pend_r ##0 ext_irq_req)
      else $error("event did not raise request");
   a_shared_output: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pin_direction_r[gpx_pkg::RST_PIN])
      else $error("reset-shared pin became input");
   a_mask_combine: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (irq_en[0] && !pin_lvl_r[0]) |-> !det_now)
      else $error("low pin failed to hold combined input low");
   a_disabled_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (irq_en == '0) |-> det_now)
      else $error("detector not high while disabled");
   a_od_float: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (pin_direction_r[0] && !pin_config_select_r[0] && pin_value_latch_r[0]
       && !alt_out_en[0]) |=> pin_oe_n[0])
      else $error("open-drain high drove the pin");
   a_wake_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wake_req == ext_irq_req)
      else $error("wake differs from request");

endmodule // gpx_port

// ---- gpx_pins.sv ----
// Pad model: resolves each pin from port drive, outside drivers and pull-up
`timescale 1ns/10ps
module gpx_pins (
   // Clock
   input  wire logic       clk_sys,
   // Port side
   input  wire logic [5:0] pin_out,
   input  wire logic [5:0] pin_oe_n,
   input  wire logic [5:0] pin_pullup,
   // Outside drivers
   input  wire logic [5:0] ext_en,
   input  wire logic [5:0] ext_val,
   // Resolved level
   output logic [5:0]      pin_lvl
);
   logic [5:0] float_r = 6'h2A;

   // Undriven pads wander so a stale level never passes for a real one
   always_ff @(posedge clk_sys) begin
      float_r <= ~float_r;
   end

   always_comb begin
      for (int i = 0; i < 6; i++) begin
         if (!pin_oe_n[i]) begin
            pin_lvl[i] = pin_out[i];
         end else if (ext_en[i]) begin
            pin_lvl[i] = ext_val[i];
         end else if (pin_pullup[i]) begin
            pin_lvl[i] = 1'h1;
         end else begin
            pin_lvl[i] = float_r[i];
         end
      end
   end
endmodule // gpx_pins

// ---- tb.sv ----
// Testbench: registers, pins, alternate function and interrupt of the port
`timescale 1ns/10ps
module tb;
   // ==========================================
   // Signals
   logic        clk_sys = 1'h0;
   logic        rst_n   = 1'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid, ext_irq_req, wake_req;
   logic [1:0]  bresp, rresp, rs;
   logic [5:0]  pin_lvl, pin_out, pin_oe_n, pin_pullup, alt_in_val, v, c, w;
   // Inputs held low by outside drivers from reset, so early reads are defined
   logic [5:0]  ext_en = 6'h37, ext_val = 6'h00, aen = 6'h00, aval = 6'h00, app = 6'h00;
   logic        fetch = 1'h0;
   int          fail_count = 0;
   int          n_checks = 0;
   localparam logic [31:0] RST_TAB [4] = '{32'h00, 32'h08, 32'h02, 32'h00};

   always #50 clk_sys = ~clk_sys;

   gpx_port dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
      .alt_out_en(aen), .alt_out_val(aval), .alt_out_pp(app), .alt_in_val(alt_in_val),
      .cpu_vec_fetch(fetch), .ext_irq_req(ext_irq_req), .wake_req(wake_req));

   gpx_pins pads (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl));

   // ==========================================
   // Tasks and expectations
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         n++;
      end while (bvalid !== 1'h1 && n < 40);
      rs = bresp;
      bready <= 1'h0;
      if (n >= 40) fail_count++;
   endtask

   task automatic rg(input logic [7:0] a);
      int n = 0;
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'h0;
         n++;
      end while (rvalid !== 1'h1 && n < 40);
      rd = rdata;
      rs = rresp;
      rready <= 1'h0;
      if (n >= 40) fail_count++;
   endtask

   // Synchroniser and edge logic need a few cycles to show a pad change
   task automatic settle();
      repeat (8) @(posedge clk_sys);
   endtask

   function automatic logic [5:0] oe_exp(logic [5:0] val, logic [5:0] dir, logic [5:0] cfg);
      return ~(dir & (cfg | ~val));
   endfunction

   function automatic logic [5:0] rd_exp(logic [5:0] val, logic [5:0] dir, logic [5:0] pins);
      return (dir & val) | (~dir & pins);
   endfunction

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Watchdog sized well above the whole sequence
   initial begin
      #(100 * 40000);
      fail_count++;
      give_verdict();
   end

   // ==========================================
   // Main sequence
   initial begin
      void'($urandom(37020));
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'h1;
      settle();
      chk(pin_oe_n[3], 1'h0);
      for (int i = 0; i < 4; i++) begin
         rg(8'(4 * i));
         chk(rd, RST_TAB[i]);
      end
      rg(8'h14);
      chk(rs, gpx_pkg::RESP_SLVERR);
      wr(8'h14, 32'h0);
      chk(rs, gpx_pkg::RESP_SLVERR);
      for (int k = 0; k < 6; k++) begin
         v = 6'($urandom);
         c = 6'($urandom);
         w = 6'($urandom);
         wr(gpx_pkg::OFF_VALUE, {26'h0, v});
         wr(gpx_pkg::OFF_CFG, {26'h0, c});
         wr(gpx_pkg::OFF_DIR, 32'h3F);
         settle();
         chk(pin_oe_n, oe_exp(v, 6'h3F, c));
         chk(pin_out | pin_oe_n, v | oe_exp(v, 6'h3F, c));
         rg(gpx_pkg::OFF_VALUE);
         chk(rd[5:0], v);
         wr(gpx_pkg::OFF_CFG, 32'h0);
         wr(gpx_pkg::OFF_DIR, 32'h0);
         ext_en <= 6'h37;
         ext_val <= c;
         wr(gpx_pkg::OFF_VALUE, {26'h0, w});
         settle();
         chk(pin_oe_n & 6'h37, 6'h37);
         rg(gpx_pkg::OFF_VALUE);
         chk(rd[5:0], rd_exp(w, 6'h08, c));
         chk(alt_in_val, rd_exp(w, 6'h08, c));
         ext_en <= 6'h00;
      end
      ext_en <= 6'h33;
      for (int j = 0; j < 2; j++) begin
         v = j ? 6'($urandom) & 6'h04 : 6'h04;
         aen <= 6'h04;
         app <= j ? 6'h04 : 6'h00;
         aval <= v;
         settle();
         chk(pin_oe_n[2], j ? 1'h0 : 1'h1);
         rg(gpx_pkg::OFF_VALUE);
         chk(rd[2], v[2]);
         if (j) chk(pin_out[2], v[2]);
      end
      aen <= 6'h00;
      ext_en <= 6'h37;
      ext_val <= 6'h37;
      wr(gpx_pkg::OFF_SENSE, 32'h1);
      wr(gpx_pkg::OFF_CFG, 32'h1);
      settle();
      chk(pin_pullup, 6'h01);
      chk(ext_irq_req, 1'h0);
      for (int k = 0; k < 4; k++) begin
         wr(gpx_pkg::OFF_SENSE, 32'h1);
         ext_val[0] <= 1'h0;
         settle();
         ext_val[0] <= 1'h1;
         settle();
         chk(ext_irq_req, 1'h1);
         chk(wake_req, 1'h1);
         rg(gpx_pkg::OFF_STATUS);
         chk(rd[0], 1'h1);
         if (k == 1) begin
            fetch <= 1'h1;
            @(posedge clk_sys);
            fetch <= 1'h0;
         end else begin
            wr(gpx_pkg::OFF_SENSE, 32'(k));
         end
         settle();
         chk(ext_irq_req, 1'h0);
      end
      ext_val[1] <= 1'h0;
      wr(gpx_pkg::OFF_CFG, 32'h3);
      wr(gpx_pkg::OFF_SENSE, 32'h1);
      ext_val[0] <= 1'h0;
      settle();
      ext_val[0] <= 1'h1;
      settle();
      chk(ext_irq_req, 1'h0);
      wr(gpx_pkg::OFF_SENSE, 32'h2);
      wr(gpx_pkg::OFF_CFG, 32'h1);
      settle();
      chk(ext_irq_req, 1'h0);
      wr(gpx_pkg::OFF_CFG, 32'h3);
      settle();
      chk(ext_irq_req, 1'h1);
      give_verdict();
   end
endmodule // tb
